// >>> dv/host_pins_model.sv
/*
  Host-side model that drives the power request and host reset pins.
  Assumes the bench commands it with plain levels and a shared core clock.
*/
`timescale 1ns/10ps
module host_pins_model (
  // clock
  input wire logic core_clk_i,
  // commands from the bench
  input wire logic want_power_i,
  input wire logic want_reset_i,
  // host pins
  output logic host_power_request_o,
  output logic host_reset_n_o
);
  // ---------------------------------------------------------------
  // pin drivers
  // ---------------------------------------------------------------
  // pins move on the falling edge, well away from the sampling edge
  // power-off is asked for by dropping the request; the rail stays up
  always @(negedge core_clk_i)
  begin
    host_power_request_o <= want_power_i;
    host_reset_n_o <= ~want_reset_i;
  end
endmodule : host_pins_model

// >>> dv/tb_top.sv
/*
  Self-checking bench for the modem power sequencer.
  Assumes the fixed pin-to-output latency and pulse handling of the hand-over.
*/
`timescale 1ns/10ps
module tb_top;
  logic core_clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic want_power = 1'b0;
  logic want_reset = 1'b0;
  logic host_power_request, host_reset_n;
  logic [5:0] fw = 6'h00;
  logic dcd_n, dsr_n, cts_n, led_n, cpu_n, radio, cold, busy;
  logic [7:0] outs;
  int n_mismatch = 0;
  int total_checks = 0;

  always #4 core_clk_i = ~core_clk_i;
  assign outs = {dcd_n, dsr_n, cts_n, led_n, cpu_n, radio, cold, busy};

  host_pins_model host (.core_clk_i(core_clk_i), .want_power_i(want_power), .want_reset_i(want_reset),
    .host_power_request_o(host_power_request), .host_reset_n_o(host_reset_n));

  // short blink so a whole toggle fits in a short run
  modem_power_sequencer #(.BLINK_HALF(4)) DUT (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
    .host_power_request_i(host_power_request), .host_reset_n_i(host_reset_n),
    .boot_done_i(fw[0]), .init_done_i(fw[1]), .dte_init_done_i(fw[2]), .reg_ack_i(fw[3]),
    .dereg_done_i(fw[4]), .save_done_i(fw[5]), .dcd_n_o(dcd_n), .dsr_n_o(dsr_n), .cts_n_o(cts_n),
    .batt_led_n_o(led_n), .cpu_reset_n_o(cpu_n), .radio_power_en_o(radio), .cold_start_o(cold),
    .shutdown_busy_o(busy));

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  task automatic stop_test;
    if (n_mismatch == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : stop_test

  // outs order: dcd dsr cts led cpu_rst radio cold busy
  task automatic chk(input logic [7:0] mask, input logic [7:0] exp);
    total_checks++;
    if ((outs & mask) !== (exp & mask))
    begin
      n_mismatch++;
      $display("BAD t=%0t got=%h exp=%h mask=%h", $time, outs, exp, mask);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask : cyc

  // one-cycle firmware progress pulse, then let the answer land
  task automatic pulse(input int idx);
    fw[idx] = 1'b1;
    cyc(1);
    fw[idx] = 1'b0;
    cyc(3);
  endtask : pulse

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values;
    chk(8'hFF, 8'hF2);
  endtask : t_reset_values

  task automatic t_power_up;
    want_power <= 1'b1;
    cyc(5);
    chk(8'hFF, 8'hDE);
    cyc(100);
    chk(8'h20, 8'h00);
    cyc(30);
    chk(8'h20, 8'h20);
    pulse(0);
    pulse(3);
    chk(8'h80, 8'h80);
    pulse(1);
    chk(8'hFB, 8'hB8);
    pulse(3);
    chk(8'h80, 8'h80);
    pulse(2);
    chk(8'hFB, 8'h98);
    pulse(3);
    chk(8'hFB, 8'h18);
  endtask : t_power_up

  task automatic t_shutdown;
    want_power <= 1'b0;
    cyc(5);
    chk(8'hDF, 8'hBD);
    cyc(3);
    chk(8'h10, 8'h00);
    cyc(4);
    chk(8'h10, 8'h10);
    pulse(4);
    chk(8'h45, 8'h01);
    pulse(5);
    chk(8'h51, 8'h50);
  endtask : t_shutdown

  task automatic t_host_reset;
    want_power <= 1'b1;
    cyc(5);
    chk(8'h08, 8'h08);
    cyc(130);
    pulse(0);
    pulse(1);
    chk(8'h42, 8'h00);
    pulse(2);
    pulse(3);
    chk(8'hE0, 8'h00);
    want_reset <= 1'b1;
    cyc(5);
    chk(8'hFA, 8'hF2);
    want_reset <= 1'b0;
    cyc(5);
    chk(8'h08, 8'h08);
  endtask : t_host_reset

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial
  begin
    cyc(8);
    rst_b_i = 1'b1;
    cyc(3);
    t_reset_values();
    t_power_up();
    t_shutdown();
    t_host_reset();
    stop_test();
  end

  // whole run needs well under a thousand cycles
  initial
  begin
    repeat (20000) @(posedge core_clk_i);
    n_mismatch++;
    stop_test();
  end
endmodule : tb_top

// >>> logic/input_sync.sv
/*
  Two-flop synchroniser for a bundle of asynchronous pin levels.
  Assumes inputs are quasi-static levels from the host.
*/
`timescale 1ns/10ps
module input_sync #(
  parameter int WIDTH = 2,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // pins
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] next_stage1;
  logic [WIDTH-1:0] next_sync;

  always_comb
  begin
    next_stage1 = async_i;
    next_sync = stage1;
  end

  // first stage feeds only the second
  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      stage1 <= INIT;
      sync_o <= INIT;
    end
    else
    begin
      stage1 <= next_stage1;
      sync_o <= next_sync;
    end
  end

endmodule : input_sync

// >>> logic/modem_power_sequencer.sv
/*
  Power-up and soft-shutdown sequencer of the radio modem.
  Assumes the host drives the power request and reset pins asynchronously,
  and that the firmware side reports boot, init and network progress as
  single-cycle done pulses on this clock.
*/
// Behaviour
// - Host reset, CTS, DSR, DCD, the LED and internal reset are all active low.
// - Power-up runs supply, power request, host reset release, internal reset release, boot, ready.
// - Dropping the power request once init has begun starts shutdown: deregister and drop DCD, save config, then drop DSR.
// - The battery indicator blinks fast during shutdown and stops when shutdown ends.
// - After deregistration the internal radio power enable is dropped.
// - A host reset gives a cold start that discards saved settings.
// - DCD shows network attachment and DSR readiness; DCD drops at deregistration start, DSR once the save ends.
// - On boot after reset CTS is asserted briefly then released.
// - DSR asserts after initialisation, CTS apart from the boot blip only once the terminal interface is up.
// - DCD asserts only after the network acknowledges registration.
`timescale 1ns/10ps
module modem_power_sequencer #(
  // blink half period in clock cycles
  parameter int BLINK_HALF = pwrseq_pkg::BLINK_HALF_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_b_i,
  // host pins
  input wire logic host_power_request_i,
  input wire logic host_reset_n_i,
  // firmware progress pulses
  input wire logic boot_done_i,
  input wire logic init_done_i,
  input wire logic dte_init_done_i,
  input wire logic reg_ack_i,
  input wire logic dereg_done_i,
  input wire logic save_done_i,
  // status pins, active low
  output logic dcd_n_o,
  output logic dsr_n_o,
  output logic cts_n_o,
  output logic batt_led_n_o,
  // internal control
  output logic cpu_reset_n_o,
  output logic radio_power_en_o,
  output logic cold_start_o,
  output logic shutdown_busy_o
);

  // ---------------------------------------------------------------
  // input synchronisation
  // ---------------------------------------------------------------
  logic [1:0] pins_sync;
  logic pwr_req;
  logic host_rst_n;

  input_sync #(
    .WIDTH(2),
    .INIT(2'h2)
  ) u_sync (
    .core_clk_i(core_clk_i),
    .rst_b_i(rst_b_i),
    .async_i({host_reset_n_i, host_power_request_i}),
    .sync_o(pins_sync)
  );

  assign pwr_req = pins_sync[0];
  assign host_rst_n = pins_sync[1];

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  pwrseq_pkg::seq_state_t state;
  pwrseq_pkg::seq_state_t next_state;
  logic [pwrseq_pkg::CNT_W-1:0] cnt;
  logic [pwrseq_pkg::CNT_W-1:0] next_cnt;
  logic [pwrseq_pkg::CNT_W-1:0] blink_cnt;
  logic [pwrseq_pkg::CNT_W-1:0] next_blink_cnt;
  logic blink;
  logic next_blink;
  logic cold;
  logic next_cold;
  pwrseq_pkg::line_status_t lines;
  pwrseq_pkg::line_status_t next_lines;
  logic next_cpu_reset_n;
  logic next_radio_en;
  logic next_busy;
  logic in_shutdown;

  assign in_shutdown = (state == pwrseq_pkg::ST_DEREG) || (state == pwrseq_pkg::ST_SAVE);

  always_comb
  begin
    next_state = state;
    next_cnt = cnt;
    next_cold = cold;
    unique case (state)
      pwrseq_pkg::ST_OFF:
      begin
        if (!host_rst_n)
          next_cold = 1'b1;
        else if (pwr_req)
          next_state = pwrseq_pkg::ST_RESET;
      end
      pwrseq_pkg::ST_RESET:
      begin
        if (!pwr_req)
          next_state = pwrseq_pkg::ST_OFF;
        else if (host_rst_n)
        begin
          next_state = pwrseq_pkg::ST_BOOT;
          next_cnt = '0;
        end
        else
          next_cold = 1'b1;
      end
      pwrseq_pkg::ST_BOOT:
      begin
        if (cnt < pwrseq_pkg::CTS_BLIP_CYC)
          next_cnt = cnt + 1'b1;
        if (boot_done_i && cnt >= pwrseq_pkg::CTS_BLIP_CYC)
          next_state = pwrseq_pkg::ST_INIT;
      end
      pwrseq_pkg::ST_INIT:
      begin
        if (init_done_i)
        begin
          next_state = pwrseq_pkg::ST_DTE_INIT;
          next_cold = 1'b0;
        end
      end
      pwrseq_pkg::ST_DTE_INIT:
        if (dte_init_done_i)
          next_state = pwrseq_pkg::ST_REGISTER;
      pwrseq_pkg::ST_REGISTER:
        if (reg_ack_i)
          next_state = pwrseq_pkg::ST_ONLINE;
      pwrseq_pkg::ST_ONLINE: ;
      pwrseq_pkg::ST_DEREG:
        if (dereg_done_i)
          next_state = pwrseq_pkg::ST_SAVE;
      pwrseq_pkg::ST_SAVE:
        if (save_done_i)
          next_state = pwrseq_pkg::ST_HALT;
      pwrseq_pkg::ST_HALT:
      begin
        if (!host_rst_n)
        begin
          next_cold = 1'b1;
          next_state = pwrseq_pkg::ST_OFF;
        end
        else if (pwr_req)
          next_state = pwrseq_pkg::ST_RESET;
      end
      default: next_state = pwrseq_pkg::ST_OFF;
    endcase
    // power request drop after init begins shutdown; off command alone does nothing
    if (!pwr_req && (state == pwrseq_pkg::ST_INIT || state == pwrseq_pkg::ST_DTE_INIT
        || state == pwrseq_pkg::ST_REGISTER || state == pwrseq_pkg::ST_ONLINE))
      next_state = pwrseq_pkg::ST_DEREG;
    // before init there is nothing to save: back to off
    if (!pwr_req && state == pwrseq_pkg::ST_BOOT)
      next_state = pwrseq_pkg::ST_OFF;
    // host reset while running forces a cold restart
    if (!host_rst_n && state != pwrseq_pkg::ST_OFF && state != pwrseq_pkg::ST_HALT
        && state != pwrseq_pkg::ST_RESET)
    begin
      next_state = pwrseq_pkg::ST_RESET;
      next_cold = 1'b1;
    end
  end

  // fast indicator blink, running only while shutdown is active
  always_comb
  begin
    next_blink_cnt = '0;
    next_blink = 1'b0;
    if (in_shutdown)
    begin
      next_blink = blink;
      if (blink_cnt >= BLINK_HALF - 1)
        next_blink = ~blink;
      else
        next_blink_cnt = blink_cnt + 1'b1;
    end
  end

  // outputs from the state being entered, so pins change with the state
  always_comb
  begin
    next_lines = pwrseq_pkg::LINES_IDLE;
    next_cpu_reset_n = 1'b1;
    next_radio_en = 1'b1;
    next_busy = 1'b0;
    unique case (next_state)
      pwrseq_pkg::ST_OFF,
      pwrseq_pkg::ST_RESET:
      begin
        next_cpu_reset_n = 1'b0;
        next_radio_en = 1'b0;
      end
      pwrseq_pkg::ST_BOOT:
        next_lines.cts_n = (next_cnt >= pwrseq_pkg::CTS_BLIP_CYC);
      pwrseq_pkg::ST_INIT: ;
      pwrseq_pkg::ST_DTE_INIT:
        next_lines.dsr_n = 1'b0;
      pwrseq_pkg::ST_REGISTER:
      begin
        next_lines.dsr_n = 1'b0;
        next_lines.cts_n = 1'b0;
      end
      pwrseq_pkg::ST_ONLINE:
      begin
        next_lines.dsr_n = 1'b0;
        next_lines.cts_n = 1'b0;
        next_lines.dcd_n = 1'b0;
      end
      pwrseq_pkg::ST_DEREG:
      begin
        next_lines.dsr_n = 1'b0;
        next_lines.batt_led_n = ~next_blink;
        next_busy = 1'b1;
      end
      pwrseq_pkg::ST_SAVE:
      begin
        next_lines.dsr_n = 1'b0;
        next_lines.batt_led_n = ~next_blink;
        next_radio_en = 1'b0;
        next_busy = 1'b1;
      end
      pwrseq_pkg::ST_HALT:
        next_radio_en = 1'b0;
      default: ;
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!rst_b_i)
    begin
      state <= pwrseq_pkg::ST_OFF;
      cnt <= '0;
      blink_cnt <= '0;
      blink <= 1'b0;
      cold <= 1'b1;
      lines <= pwrseq_pkg::LINES_IDLE;
      cpu_reset_n_o <= 1'b0;
      radio_power_en_o <= 1'b0;
      shutdown_busy_o <= 1'b0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
      cold <= next_cold;
      lines <= next_lines;
      cpu_reset_n_o <= next_cpu_reset_n;
      radio_power_en_o <= next_radio_en;
      shutdown_busy_o <= next_busy;
    end
  end

  assign dcd_n_o = lines.dcd_n;
  assign dsr_n_o = lines.dsr_n;
  assign cts_n_o = lines.cts_n;
  assign batt_led_n_o = lines.batt_led_n;
  assign cold_start_o = cold;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence s_shutdown_start;
    $fell(pwr_req) && (state == pwrseq_pkg::ST_ONLINE) && host_rst_n;
  endsequence

  property p_dcd_drop;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    s_shutdown_start |=> dcd_n_o && !dsr_n_o && shutdown_busy_o;
  endproperty
  a_dcd_drop: assert property (p_dcd_drop) else $error("dcd not dropped at shutdown start");

  property p_dsr_after_save;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (state == pwrseq_pkg::ST_SAVE) && save_done_i && host_rst_n |=> dsr_n_o && !shutdown_busy_o;
  endproperty
  a_dsr_after_save: assert property (p_dsr_after_save) else $error("dsr not dropped after save");

  property p_radio_off;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (state == pwrseq_pkg::ST_DEREG) && dereg_done_i && host_rst_n |=> !radio_power_en_o;
  endproperty
  a_radio_off: assert property (p_radio_off) else $error("radio still powered after deregistration");

  property p_led_quiet;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !shutdown_busy_o |-> batt_led_n_o;
  endproperty
  a_led_quiet: assert property (p_led_quiet) else $error("indicator lit outside shutdown");

  property p_dcd_needs_ack;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $fell(dcd_n_o) |-> $past(reg_ack_i);
  endproperty
  a_dcd_needs_ack: assert property (p_dcd_needs_ack) else $error("dcd asserted without network ack");

  property p_cts_needs_dsr;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    (state == pwrseq_pkg::ST_INIT) |-> cts_n_o && dsr_n_o;
  endproperty
  a_cts_needs_dsr: assert property (p_cts_needs_dsr) else $error("cts or dsr early during init");

  property p_cts_blip;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(cpu_reset_n_o) |-> !cts_n_o [*2];
  endproperty
  a_cts_blip: assert property (p_cts_blip) else $error("cts blip missing at boot");

  property p_reset_cold;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    !host_rst_n && (state == pwrseq_pkg::ST_ONLINE) |=> !cpu_reset_n_o && cold_start_o && dsr_n_o;
  endproperty
  a_reset_cold: assert property (p_reset_cold) else $error("host reset did not cold start");

  property p_sync_delay;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    pwr_req |-> $past(host_power_request_i, 2);
  endproperty
  a_sync_delay: assert property (p_sync_delay) else $error("power request not two-stage synchronised");

  property p_up_order;
    @(posedge core_clk_i) disable iff (!rst_b_i)
    $rose(cpu_reset_n_o) |-> pwr_req && $past(host_rst_n);
  endproperty
  a_up_order: assert property (p_up_order) else $error("internal reset released out of order");

endmodule : modem_power_sequencer

// >>> pkg/pwrseq_pkg.sv
/*
  Package for the modem power sequencer: state encoding, timing constants
  and the packed status carrier.
  Assumes a 125 MHz core clock.
*/
package pwrseq_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 8;
  localparam int CTS_BLIP_NS = 1000;
  localparam int CTS_BLIP_CYC = (CTS_BLIP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLINK_HALF_NS = 100000000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_NS / CLK_PERIOD_NS;
  localparam int SHUTDOWN_MAX_MS = 10000;
  localparam int SHUTDOWN_MAX_CYC = SHUTDOWN_MAX_MS * 125000;
  localparam int CNT_W = 32;

  // ---------------------------------------------------------------
  // sequencer states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    ST_OFF = 4'h0,
    ST_RESET = 4'h1,
    ST_BOOT = 4'h2,
    ST_INIT = 4'h3,
    ST_DTE_INIT = 4'h4,
    ST_REGISTER = 4'h5,
    ST_ONLINE = 4'h6,
    ST_DEREG = 4'h7,
    ST_SAVE = 4'h8,
    ST_HALT = 4'h9
  } seq_state_t;

  // ---------------------------------------------------------------
  // status lines, all active low
  // ---------------------------------------------------------------
  typedef struct packed {
    logic dcd_n;
    logic dsr_n;
    logic cts_n;
    logic batt_led_n;
  } line_status_t;

  localparam line_status_t LINES_IDLE = 4'hF;

endpackage : pwrseq_pkg
